// File: ofr_pkg.sv
// Package of constants and carrier types for the octal framer receive backplane control block
// Behaviour
// - Interrupt identifier bit set per interrupting framer
// - Pattern unit attached to one selected framer
// - Swap bit moves generator and detector paths
// - Unframed generate covers all 32 timeslots
// - Unframed detect covers all 32 timeslots
// - Monitor bit sets on edge, read clears
// - Five monitor bits at positions four to zero
// - Pulse selects 00 force low, 10 shaped
// - Reference select copies common frame pulse
// - Out of multiframe E-bits take inverse of mode bit
// - Criterion ignored unless automatic alarm enabled
// - Criterion 0 alarms on four conditions
// - Criterion 1 alarms on frame loss, AIS
// - Master mode fraction field picks mode
// - Full mode clocks every bit, no gaps
// - Fractional mode clocks selected timeslots only
// - F-bit mode cuts from timeslot 26 bit 1
// - Data edge bit picks data update edge
// - Frame edge bit picks pulse edge
// - Differing edges delay pulse one edge
// - Default options pulse first bit each frame
package ofr_pkg;

  // ==========================================================
  // Register map
  localparam logic [9:0] OFR_ADDR_INT_ID = 10'h00b;
  localparam logic [9:0] OFR_ADDR_PAT_CTRL = 10'h00c;
  localparam logic [9:0] OFR_ADDR_CLK_MON = 10'h00d;
  localparam logic [9:0] OFR_ADDR_FP_CFG = 10'h00e;
  localparam logic [9:0] OFR_ADDR_BP_CFG = 10'h010;
  localparam logic [9:0] OFR_FRAMER_STRIDE = 10'h080;

  // ==========================================================
  // Field positions
  localparam int OFR_PAT_SEL_LSB = 5;
  localparam int OFR_PAT_SWAP_BIT = 2;
  localparam int OFR_PAT_UNFRAMED_GENERATE_BIT = 1;
  localparam int OFR_PAT_UNFRAMED_DETECT_BIT = 0;
  localparam int OFR_MON_XCK_BIT = 4;
  localparam int OFR_MON_TSB_BIT = 3;
  localparam int OFR_MON_TSA_BIT = 2;
  localparam int OFR_MON_RSC_BIT = 1;
  localparam int OFR_MON_LRC_BIT = 0;
  localparam int OFR_FP_PERTS_BIT = 3;
  localparam int OFR_FP_REF_BIT = 2;
  localparam int OFR_FP_EBIT_BIT = 1;
  localparam int OFR_FP_RAI_BIT = 0;
  localparam int OFR_BP_FRACT_LSB = 6;
  localparam int OFR_BP_SLAVE_BIT = 5;
  localparam int OFR_BP_DE_BIT = 4;
  localparam int OFR_BP_FE_BIT = 3;
  localparam int OFR_MON_BITS = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:0] OFR_INT_ID_RST = 8'h00;
  localparam logic [7:0] OFR_PAT_RST = 8'h00;
  localparam logic [7:0] OFR_MON_RST = 8'h00;
  localparam logic [7:0] OFR_FP_RST = 8'h00;
  localparam logic [7:0] OFR_BP_RST = 8'h38;

  // ==========================================================
  // Frame timing counts
  localparam logic [7:0] OFR_LAST_BIT = 8'hff;
  localparam logic [7:0] OFR_FBIT_CUT = 8'hd1;
  localparam logic [4:0] OFR_TS_SIG = 5'h10;

  typedef enum logic [1:0] {
    OFR_FULL = 2'b00,
    OFR_RSVD = 2'b01,
    OFR_FRAC_FBIT = 2'b11,
    OFR_FRAC = 2'b10
  } ofr_fract_t;

  typedef struct packed {
    logic ohm;
    logic smfp;
    logic cmfp;
    logic alt;
  } ofr_fp_opt_t;

  typedef struct packed {
    logic out_of_mf;
    logic lof;
    logic ais;
    logic interwork;
    logic offline_oof;
  } ofr_alarm_in_t;

  typedef struct packed {
    ofr_fract_t fract;
    logic slave;
    logic de;
    logic fe;
    logic per_ts;
    logic ref_sel;
    ofr_fp_opt_t opt;
    logic [31:0] ts_sel;
  } ofr_link_cfg_t;

  localparam int OFR_CFG_W = $bits(ofr_link_cfg_t);
  localparam logic [OFR_CFG_W-1:0] OFR_CFG_RST = {2'b00, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0,
                                                  32'h0000_0000};

endpackage

// File: ofr_word_cdc.sv
// Toggle handshake carrying one configuration word into the link clock domain
module ofr_word_cdc #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] src_data,
  input wire logic link_clk,
  input wire logic link_srst,
  output logic [W-1:0] dst_data
);

  typedef struct packed {
    logic [W-1:0] pend;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic busy;
  } ofr_cdc_src_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic seen;
    logic [W-1:0] data;
  } ofr_cdc_dst_t;

  ofr_cdc_src_t s_q, s_d;
  ofr_cdc_dst_t d_q, d_d;

  // ==========================================================
  // Source side: hold the word stable until the far side acknowledges
  always_comb begin
    s_d = s_q;
    s_d.ack_s1 = d_q.seen;
    s_d.ack_s2 = s_q.ack_s1;
    if (s_q.busy && (s_q.ack_s2 == s_q.req)) begin
      s_d.busy = 1'b0;
    end else if (!s_q.busy && (src_data != s_q.pend)) begin
      s_d.pend = src_data;
      s_d.req = ~s_q.req;
      s_d.busy = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '{pend: RST, req: 1'b0, ack_s1: 1'b0, ack_s2: 1'b0, busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Destination side: a new toggle means the held word is stable
  always_comb begin
    d_d = d_q;
    d_d.req_s1 = s_q.req;
    d_d.req_s2 = d_q.req_s1;
    if (d_q.req_s2 != d_q.seen) begin
      d_d.data = s_q.pend;
      d_d.seen = d_q.req_s2;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      d_q <= '{req_s1: 1'b0, req_s2: 1'b0, seen: 1'b0, data: RST};
    end else begin
      d_q <= d_d;
    end
  end

  assign dst_data = d_q.data;

endmodule

// File: ofr_rx_backplane_ctrl.sv
// Control and status registers and receive backplane timing of the octal framer
module ofr_rx_backplane_ctrl #(
  parameter logic [2:0] FRAMER_IDX = 3'h0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [9:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  input wire logic [7:0] framer_int_req,
  output logic int_n,
  input wire logic [31:0] tx_payload_control,
  input wire logic [31:0] rx_payload_control,
  input wire logic [31:0] timeslot_select_bit,
  output logic [7:0] pat_framer_onehot,
  output logic pat_gen_tx,
  output logic pat_gen_rx,
  output logic pat_det_tx,
  output logic pat_det_rx,
  output logic [31:0] pat_gen_ts_mask,
  output logic [31:0] pat_det_ts_mask,
  input wire ofr_pkg::ofr_fp_opt_t fp_opt,
  input wire logic auto_remote_alarm_enable,
  input wire ofr_pkg::ofr_alarm_in_t alarm_in,
  output logic ebit_force,
  output logic ebit_value,
  output logic remote_alarm_send,
  input wire logic reference_crystal_clock,
  input wire logic tx_system_clock_b,
  input wire logic tx_system_clock_a,
  input wire logic rx_system_common_clock,
  input wire logic line_receive_clock,
  input wire logic rx_link_clk,
  input wire logic rx_bit_in,
  input wire logic rx_sig_in,
  input wire logic rx_common_frame_pulse_in,
  output logic rx_system_data,
  output logic rx_system_signaling,
  output logic rx_frame_pulse_out,
  output logic rx_system_per_link_clock
);

  localparam int MW = ofr_pkg::OFR_MON_BITS;
  localparam logic [9:0] BASE = 10'(FRAMER_IDX) * ofr_pkg::OFR_FRAMER_STRIDE;

  // ==========================================================
  // Register domain state
  typedef struct packed {
    logic [7:0] int_id;
    logic [7:0] pat;
    logic [7:0] mon;
    logic [7:0] fp;
    logic [7:0] bp;
    logic [MW-1:0] mon_s1;
    logic [MW-1:0] mon_s2;
    logic [MW-1:0] mon_s3;
    logic [7:0] rdata;
    logic rvalid;
    logic int_n;
    logic [7:0] onehot;
    logic gen_tx;
    logic gen_rx;
    logic det_tx;
    logic det_rx;
    logic [31:0] gen_mask;
    logic [31:0] det_mask;
    logic ebit_force;
    logic ebit_value;
    logic rai;
  } ofr_reg_state_t;

  ofr_reg_state_t r_q, r_d;
  logic [MW-1:0] mon_pins;
  logic [MW-1:0] mon_rise;
  logic rai_cond;
  ofr_pkg::ofr_link_cfg_t cfg_src;
  ofr_pkg::ofr_link_cfg_t cfg_link;
  logic [ofr_pkg::OFR_CFG_W-1:0] cfg_link_w;

  assign mon_pins = {reference_crystal_clock, tx_system_clock_b, tx_system_clock_a,
                     rx_system_common_clock, line_receive_clock};

  // Edges are detected only behind two synchroniser stages
  assign mon_rise = r_q.mon_s2 & ~r_q.mon_s3;

  always_comb begin
    if (!auto_remote_alarm_enable) begin
      rai_cond = 1'b0;
    end else if (r_q.fp[ofr_pkg::OFR_FP_RAI_BIT]) begin
      rai_cond = alarm_in.lof | alarm_in.ais;
    end else begin
      rai_cond = alarm_in.lof | alarm_in.ais | alarm_in.interwork
                 | alarm_in.offline_oof;
    end
  end

  always_comb begin
    r_d = r_q;
    r_d.mon_s1 = mon_pins;
    r_d.mon_s2 = r_q.mon_s1;
    r_d.mon_s3 = r_q.mon_s2;
    r_d.rvalid = 1'b0;

    // Identifier follows the framers currently requesting service
    r_d.int_id = framer_int_req;
    r_d.int_n = ~(|framer_int_req);

    // A read of the clock monitor clears it, but an edge seen now still sets its bit
    r_d.mon = r_q.mon | {3'h0, mon_rise};

    if (cpu_rd) begin
      r_d.rvalid = 1'b1;
      case (cpu_addr)
        ofr_pkg::OFR_ADDR_INT_ID: begin
          r_d.rdata = r_q.int_id;
        end
        ofr_pkg::OFR_ADDR_PAT_CTRL: begin
          r_d.rdata = r_q.pat;
        end
        BASE + ofr_pkg::OFR_ADDR_CLK_MON: begin
          r_d.rdata = r_q.mon;
          r_d.mon = {3'h0, mon_rise};
        end
        BASE + ofr_pkg::OFR_ADDR_FP_CFG: begin
          r_d.rdata = r_q.fp;
        end
        BASE + ofr_pkg::OFR_ADDR_BP_CFG: begin
          r_d.rdata = r_q.bp;
        end
        default: begin
          r_d.rdata = 8'h00;
        end
      endcase
    end

    if (cpu_wr) begin
      case (cpu_addr)
        ofr_pkg::OFR_ADDR_PAT_CTRL: begin
          r_d.pat = cpu_wdata & 8'he7;
        end
        BASE + ofr_pkg::OFR_ADDR_FP_CFG: begin
          r_d.fp = cpu_wdata & 8'h0f;
        end
        BASE + ofr_pkg::OFR_ADDR_BP_CFG: begin
          r_d.bp = cpu_wdata;
        end
        default: begin
          r_d.bp = r_q.bp;
        end
      endcase
    end

    // Pattern unit placement from the registered control
    r_d.onehot = 8'h01 << r_q.pat[ofr_pkg::OFR_PAT_SEL_LSB +: 3];
    r_d.gen_tx = ~r_q.pat[ofr_pkg::OFR_PAT_SWAP_BIT];
    r_d.det_rx = ~r_q.pat[ofr_pkg::OFR_PAT_SWAP_BIT];
    r_d.gen_rx = r_q.pat[ofr_pkg::OFR_PAT_SWAP_BIT];
    r_d.det_tx = r_q.pat[ofr_pkg::OFR_PAT_SWAP_BIT];

    if (r_q.pat[ofr_pkg::OFR_PAT_UNFRAMED_GENERATE_BIT]) begin
      r_d.gen_mask = 32'hffff_ffff;
    end else if (r_q.pat[ofr_pkg::OFR_PAT_SWAP_BIT]) begin
      r_d.gen_mask = rx_payload_control;
    end else begin
      r_d.gen_mask = tx_payload_control;
    end

    if (r_q.pat[ofr_pkg::OFR_PAT_UNFRAMED_DETECT_BIT]) begin
      r_d.det_mask = 32'hffff_ffff;
    end else if (r_q.pat[ofr_pkg::OFR_PAT_SWAP_BIT]) begin
      r_d.det_mask = tx_payload_control;
    end else begin
      r_d.det_mask = rx_payload_control;
    end

    // E-bits forced only while multiframe alignment is lost
    r_d.ebit_force = alarm_in.out_of_mf;
    r_d.ebit_value = ~r_q.fp[ofr_pkg::OFR_FP_EBIT_BIT];
    r_d.rai = rai_cond;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r_q <= '0;
      r_q.int_id <= ofr_pkg::OFR_INT_ID_RST;
      r_q.pat <= ofr_pkg::OFR_PAT_RST;
      r_q.mon <= ofr_pkg::OFR_MON_RST;
      r_q.fp <= ofr_pkg::OFR_FP_RST;
      r_q.bp <= ofr_pkg::OFR_BP_RST;
      r_q.int_n <= 1'b1;
      r_q.onehot <= 8'h01;
      r_q.gen_tx <= 1'b1;
      r_q.det_rx <= 1'b1;
      r_q.ebit_value <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign cpu_rdata = r_q.rdata;
  assign cpu_rvalid = r_q.rvalid;
  assign int_n = r_q.int_n;
  assign pat_framer_onehot = r_q.onehot;
  assign pat_gen_tx = r_q.gen_tx;
  assign pat_gen_rx = r_q.gen_rx;
  assign pat_det_tx = r_q.det_tx;
  assign pat_det_rx = r_q.det_rx;
  assign pat_gen_ts_mask = r_q.gen_mask;
  assign pat_det_ts_mask = r_q.det_mask;
  assign ebit_force = r_q.ebit_force;
  assign ebit_value = r_q.ebit_value;
  assign remote_alarm_send = r_q.rai;

  // ==========================================================
  // Configuration crossing into the link clock domain
  always_comb begin
    cfg_src.fract = ofr_pkg::ofr_fract_t'(r_q.bp[ofr_pkg::OFR_BP_FRACT_LSB +: 2]);
    cfg_src.slave = r_q.bp[ofr_pkg::OFR_BP_SLAVE_BIT];
    cfg_src.de = r_q.bp[ofr_pkg::OFR_BP_DE_BIT];
    cfg_src.fe = r_q.bp[ofr_pkg::OFR_BP_FE_BIT];
    cfg_src.per_ts = r_q.fp[ofr_pkg::OFR_FP_PERTS_BIT];
    cfg_src.ref_sel = r_q.fp[ofr_pkg::OFR_FP_REF_BIT];
    cfg_src.opt = fp_opt;
    cfg_src.ts_sel = timeslot_select_bit;
  end

  logic lrst_s1, lrst_s2;

  always_ff @(posedge rx_link_clk) begin
    lrst_s1 <= srst;
    lrst_s2 <= lrst_s1;
  end

  ofr_word_cdc #(
    .W(ofr_pkg::OFR_CFG_W),
    .RST(ofr_pkg::OFR_CFG_RST)
  ) u_cfg_cdc (
    .clk(clk),
    .srst(srst),
    .src_data(cfg_src),
    .link_clk(rx_link_clk),
    .link_srst(lrst_s2),
    .dst_data(cfg_link_w)
  );

  assign cfg_link = ofr_pkg::ofr_link_cfg_t'(cfg_link_w);

  // ==========================================================
  // Link domain: backplane clock at twice the bit rate
  typedef struct packed {
    logic phase;
    logic [7:0] bit_cnt;
    logic [4:0] frame_cnt;
    logic align;
    logic gate;
    logic fp_hold;
    logic data;
    logic sig;
    logic fp_out;
    logic clk_out;
  } ofr_link_state_t;

  ofr_link_state_t l_q, l_d;
  logic rise_edge;
  logic data_edge;
  logic fp_edge;
  logic [7:0] nb;
  logic [4:0] nf;
  logic new_gate;
  logic fp_val;
  logic first_bit;
  ofr_pkg::ofr_fract_t eff_fract;

  always_comb begin
    rise_edge = ~l_q.phase;
    data_edge = (cfg_link.de == rise_edge);
    fp_edge = (cfg_link.fe == rise_edge);
    eff_fract = cfg_link.slave ? ofr_pkg::OFR_FULL : cfg_link.fract;

    if (l_q.align) begin
      nb = 8'h00;
      nf = l_q.frame_cnt + 5'h01;
    end else if (l_q.bit_cnt == ofr_pkg::OFR_LAST_BIT) begin
      nb = 8'h00;
      nf = l_q.frame_cnt + 5'h01;
    end else begin
      nb = l_q.bit_cnt + 8'h01;
      nf = l_q.frame_cnt;
    end

    case (eff_fract)
      ofr_pkg::OFR_FRAC: begin
        new_gate = cfg_link.ts_sel[nb[7:3]];
      end
      ofr_pkg::OFR_FRAC_FBIT: begin
        new_gate = cfg_link.ts_sel[nb[7:3]] & (nb < ofr_pkg::OFR_FBIT_CUT);
      end
      default: begin
        new_gate = 1'b1;
      end
    endcase

    first_bit = (nb == 8'h00);
    if (cfg_link.opt.ohm) begin
      fp_val = (nb[7:3] == 5'h00) | (nb[7:3] == ofr_pkg::OFR_TS_SIG);
    end else if (!cfg_link.opt.smfp && !cfg_link.opt.cmfp) begin
      fp_val = first_bit & (~cfg_link.opt.alt | ~nf[0]);
    end else begin
      fp_val = first_bit & (nf[3:0] == 4'h0) & (~cfg_link.opt.alt | ~nf[4]);
    end
    if (!cfg_link.per_ts) begin
      fp_val = 1'b0;
    end
  end

  always_comb begin
    l_d = l_q;
    l_d.phase = ~l_q.phase;
    l_d.clk_out = l_q.gate & rise_edge;

    if (data_edge) begin
      l_d.bit_cnt = nb;
      l_d.frame_cnt = nf;
      l_d.align = 1'b0;
      l_d.gate = new_gate;
      l_d.fp_hold = fp_val;
      l_d.data = rx_bit_in;
      l_d.sig = rx_sig_in;
    end

    // Set after the data update so a pulse sampled on a data edge is kept
    if (fp_edge && cfg_link.slave && rx_common_frame_pulse_in) begin
      l_d.align = 1'b1;
    end

    if (fp_edge) begin
      if (cfg_link.ref_sel) begin
        l_d.fp_out = rx_common_frame_pulse_in;
      end else if (data_edge) begin
        l_d.fp_out = fp_val;
      end else begin
        // Pulse follows its data one link edge later
        l_d.fp_out = l_q.fp_hold;
      end
    end
  end

  always_ff @(posedge rx_link_clk) begin
    if (lrst_s2) begin
      l_q <= '0;
      l_q.bit_cnt <= ofr_pkg::OFR_LAST_BIT;
      l_q.gate <= 1'b1;
    end else begin
      l_q <= l_d;
    end
  end

  assign rx_system_data = l_q.data;
  assign rx_system_signaling = l_q.sig;
  assign rx_frame_pulse_out = l_q.fp_out;
  assign rx_system_per_link_clock = l_q.clk_out;

endmodule

// File: ofr_rx_backplane_ctrl_sva.sv
// Port checker of the receive backplane control block
module ofr_rx_backplane_ctrl_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic cpu_rd,
  input wire logic cpu_rvalid,
  input wire logic [7:0] cpu_rdata,
  input wire logic [7:0] framer_int_req,
  input wire logic int_n,
  input wire logic [7:0] pat_framer_onehot,
  input wire logic pat_gen_tx,
  input wire logic pat_gen_rx,
  input wire logic pat_det_tx,
  input wire logic pat_det_rx,
  input wire logic [31:0] tx_payload_control,
  input wire logic [31:0] rx_payload_control,
  input wire logic [31:0] pat_gen_ts_mask,
  input wire logic auto_remote_alarm_enable,
  input wire ofr_pkg::ofr_alarm_in_t alarm_in,
  input wire logic ebit_force,
  input wire logic remote_alarm_send
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  AST_RD_ANSWER: assert property (cpu_rd |=> cpu_rvalid)
    else $error("read not answered");
  AST_RVALID_CAUSE: assert property (cpu_rvalid |-> $past(cpu_rd))
    else $error("answer without read");
  AST_RDATA_HOLD: assert property (!$past(srst) && !$past(cpu_rd) |-> $stable(cpu_rdata))
    else $error("read data moved");
  AST_INT_LINE: assert property (!$past(srst) |-> int_n == !(|$past(framer_int_req)))
    else $error("interrupt line wrong");
  AST_ONE_FRAMER: assert property ($onehot(pat_framer_onehot))
    else $error("pattern unit not on one framer");
  AST_SWAP: assert property (pat_gen_tx == pat_det_rx && pat_gen_rx == pat_det_tx
    && pat_gen_tx != pat_gen_rx) else $error("pattern paths wrong");
  AST_GEN_MASK: assert property (!$past(srst) |-> (&pat_gen_ts_mask)
    || pat_gen_ts_mask == (pat_gen_tx ? $past(tx_payload_control)
    : $past(rx_payload_control))) else $error("generate mask wrong");
  AST_EBIT: assert property (!$past(srst) |-> ebit_force == $past(alarm_in.out_of_mf))
    else $error("ebit force wrong");
  AST_RAI_IGNORED: assert property (!$past(srst) && !$past(auto_remote_alarm_enable)
    |-> !remote_alarm_send) else $error("alarm sent while disabled");
  AST_RAI_CORE: assert property (!$past(srst) && $past(auto_remote_alarm_enable
    && (alarm_in.lof || alarm_in.ais)) |-> remote_alarm_send) else $error("alarm missing");
endmodule

bind ofr_rx_backplane_ctrl ofr_rx_backplane_ctrl_sva ofr_rx_backplane_ctrl_sva_i (
  .clk(clk), .srst(srst), .cpu_rd(cpu_rd), .cpu_rvalid(cpu_rvalid), .cpu_rdata(cpu_rdata),
  .framer_int_req(framer_int_req), .int_n(int_n), .pat_framer_onehot(pat_framer_onehot),
  .pat_gen_tx(pat_gen_tx), .pat_gen_rx(pat_gen_rx), .pat_det_tx(pat_det_tx),
  .pat_det_rx(pat_det_rx), .tx_payload_control(tx_payload_control),
  .rx_payload_control(rx_payload_control), .pat_gen_ts_mask(pat_gen_ts_mask),
  .auto_remote_alarm_enable(auto_remote_alarm_enable), .alarm_in(alarm_in),
  .ebit_force(ebit_force), .remote_alarm_send(remote_alarm_send));

// File: ofr_far_model.sv
// Far-side model: link clock, receive stream, common pulse and monitored clocks
module ofr_far_model (
  input wire logic [4:0] mon_en,
  output logic rx_link_clk,
  output logic rx_bit_in,
  output logic rx_sig_in,
  output logic rx_common_frame_pulse_in,
  output logic [4:0] mon_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] edge_q = 9'h000;
  logic [15:0] lfsr_q = 16'hace1;
  int cnt = 0;
  initial begin
    rx_link_clk = 1'b0;
    rx_bit_in = 1'b0;
    rx_sig_in = 1'b0;
    rx_common_frame_pulse_in = 1'b0;
    mon_clk = 5'h00;
    #7;
    forever #40 rx_link_clk = ~rx_link_clk;
  end
  // ==========================================================
  // One frame is 512 link edges; the common pulse spans one bit
  always @(posedge rx_link_clk) begin
    edge_q <= edge_q + 9'h001;
    lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    rx_bit_in <= lfsr_q[0];
    rx_sig_in <= lfsr_q[5];
    rx_common_frame_pulse_in <= (edge_q < 9'h002);
  end
  // Disabled clocks rest low; half periods 90 to 170 ns
  always #10 begin
    cnt++;
    for (int i = 0; i < 5; i++) begin
      if (cnt % (9 + 2 * i) == 0) begin
        mon_clk[i] = mon_en[i] & ~mon_clk[i];
      end
    end
  end
endmodule

// File: ofr_rx_backplane_ctrl_test.sv
// Self-checking bench of the receive backplane control block
module ofr_rx_backplane_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cpu_rd = 1'b0;
  logic cpu_wr = 1'b0;
  logic [9:0] cpu_addr = 10'h000;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata, onehot, int_req = 8'h00;
  logic cpu_rvalid, int_n, gen_tx, gen_rx, det_tx, det_rx, ebit_f, ebit_v, rai, auto_rai = 1'b0;
  logic [31:0] tx_pl = '0, rx_pl = '0, tssel = '0, gmask, dmask;
  ofr_pkg::ofr_fp_opt_t fp_opt = '0;
  ofr_pkg::ofr_alarm_in_t alarm = '0;
  logic [4:0] mon_en = 5'h00, mon_clk;
  logic lclk, bit_in, sig_in, cfp, fp_out, lck, sd, ss;
  int errors = 0;
  int total_checks = 0;

  always #10 clk = ~clk;

  ofr_far_model ofr_far_model_i (.mon_en(mon_en), .rx_link_clk(lclk), .rx_bit_in(bit_in),
    .rx_sig_in(sig_in), .rx_common_frame_pulse_in(cfp), .mon_clk(mon_clk));

  ofr_rx_backplane_ctrl ofr_rx_backplane_ctrl_i (.clk(clk), .srst(srst), .cpu_rd(cpu_rd),
    .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .framer_int_req(int_req), .int_n(int_n),
    .tx_payload_control(tx_pl), .rx_payload_control(rx_pl), .timeslot_select_bit(tssel),
    .pat_framer_onehot(onehot), .pat_gen_tx(gen_tx), .pat_gen_rx(gen_rx),
    .pat_det_tx(det_tx), .pat_det_rx(det_rx), .pat_gen_ts_mask(gmask),
    .pat_det_ts_mask(dmask), .fp_opt(fp_opt), .auto_remote_alarm_enable(auto_rai),
    .alarm_in(alarm), .ebit_force(ebit_f), .ebit_value(ebit_v), .remote_alarm_send(rai),
    .reference_crystal_clock(mon_clk[4]), .tx_system_clock_b(mon_clk[3]),
    .tx_system_clock_a(mon_clk[2]), .rx_system_common_clock(mon_clk[1]),
    .line_receive_clock(mon_clk[0]), .rx_link_clk(lclk), .rx_bit_in(bit_in),
    .rx_sig_in(sig_in), .rx_common_frame_pulse_in(cfp), .rx_system_data(sd),
    .rx_system_signaling(ss), .rx_frame_pulse_out(fp_out), .rx_system_per_link_clock(lck));

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask

  task automatic rc(input logic [9:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge clk);
    cpu_rd <= 1'b0;
    @(negedge clk);
    chk("read answer", 1'b1, cpu_rvalid);
    chk(nm, e, cpu_rdata);
  endtask

  function automatic int clk_exp(logic [7:0] bp, logic [31:0] sel);
    int n;
    n = 0;
    for (int t = 0; t < 32; t++) begin
      if (bp[5] || !bp[7]) n += 8;
      else if (sel[t]) n += !bp[6] ? 8 : (t < 26 ? 8 : (t == 26 ? 1 : 0));
    end
    return 2 * n;
  endfunction

  function automatic logic rai_exp(logic en, logic crit, ofr_pkg::ofr_alarm_in_t a);
    return en && (a.lof || a.ais || (!crit && (a.interwork || a.offline_oof)));
  endfunction

  // Counts gated clock and frame pulse rises over two frames
  task automatic link(input logic [7:0] bp, input logic [3:0] fp, input logic [3:0] opt,
                      input int efp);
    int nc, nf, nd;
    logic pc, pf, pb, ps;
    wr(10'h010, bp);
    wr(10'h00e, {4'h0, fp});
    fp_opt <= opt;
    rc(10'h010, bp, "backplane cfg");
    repeat (40) @(posedge lclk);
    #20;
    nc = 0;
    nf = 0;
    nd = 0;
    pc = lck;
    pf = fp_out;
    pb = bit_in;
    ps = sig_in;
    repeat (2048) begin
      @(lclk);
      #20;
      if (lclk && (bp[4] ? (lck && !pc) : (pc && !lck))) nd += ({sd, ss} !== {pb, ps});
      nc += (lck && !pc);
      nf += (fp_out && !pf);
      pc = lck;
      pf = fp_out;
      if (!lclk) {pb, ps} = {bit_in, sig_in};
    end
    chk("gated clock pulses", clk_exp(bp, tssel), nc);
    chk("frame pulses", efp, nf);
    chk("data follows input", 0, nd);
    $display("test link %h %h done", bp, fp);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #1600000;
    errors++;
    $display("ERROR watchdog expected finish seen timeout");
    tally_and_finish();
  end

  // ==========================================================
  // Test sequence
  initial begin
    logic [9:0] ra [6];
    logic [7:0] rv [6];
    logic [7:0] v;
    logic e;
    ofr_pkg::ofr_alarm_in_t a;
    ra = '{10'h00b, 10'h00c, 10'h00d, 10'h00e, 10'h010, 10'h011};
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h38, 8'h00};
    void'($urandom(58782));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    tx_pl <= $urandom;
    rx_pl <= $urandom;
    tssel <= $urandom | 32'h1;
    for (int i = 0; i < 6; i++) rc(ra[i], rv[i], "reset value");
    $display("test reset done");
    wr(10'h00b, 8'hff);
    wr(10'h011, 8'hff);
    rc(10'h011, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      @(posedge clk);
      int_req <= v;
      rc(10'h00b, v, "interrupt id");
      chk("int_n", !(|v), int_n);
    end
    $display("test interrupt done");
    for (int i = 0; i < 8; i++) begin
      v = {3'(i), 5'($urandom)};
      wr(10'h00c, v);
      rc(10'h00c, v & 8'he7, "pattern control");
      chk("framer select", 8'h01 << i, onehot);
      chk("paths", {!v[2], v[2], v[2], !v[2]}, {gen_tx, gen_rx, det_tx, det_rx});
      chk("gen mask", v[1] ? 32'hffffffff : (v[2] ? rx_pl : tx_pl), gmask);
      chk("det mask", v[0] ? 32'hffffffff : (v[2] ? tx_pl : rx_pl), dmask);
    end
    $display("test pattern done");
    for (int i = 0; i < 5; i++) begin
      mon_en <= 5'h01 << i;
      repeat (60) @(posedge clk);
      mon_en <= 5'h00;
      repeat (20) @(posedge clk);
      rc(10'h00d, 8'h01 << i, "clock monitor");
      rc(10'h00d, 8'h00, "monitor cleared");
    end
    $display("test monitor done");
    for (int k = 0; k < 16; k++) begin
      wr(10'h00e, 8'(k));
      rc(10'h00e, 8'(k), "frame pulse cfg");
      for (int j = 0; j < 3; j++) begin
        a = 5'($urandom);
        e = 1'($urandom);
        @(posedge clk);
        alarm <= a;
        auto_rai <= e;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("ebit value", !k[1], ebit_v);
        chk("remote alarm", rai_exp(e, k[0], a), rai);
      end
    end
    $display("test alarm done");
    // Let the first common pulse align the slave bit counter
    repeat (520) @(posedge lclk);
    link(8'h38, 4'h0, 4'h0, 0);
    link(8'h38, 4'h8, 4'h0, 2);
    link(8'h38, 4'h8, 4'h1, 1);
    link(8'h38, 4'h4, 4'h0, 2);
    link(8'h38, 4'hc, 4'h0, 2);
    link(8'h18, 4'h8, 4'h0, 2);
    link(8'h58, 4'h8, 4'h0, 2);
    link(8'h98, 4'h8, 4'h0, 2);
    link(8'hd8, 4'h8, 4'h0, 2);
    link(8'hbb, 4'h8, 4'h0, 2);
    link(8'h08, 4'h8, 4'h0, 2);
    link(8'h10, 4'h8, 4'h0, 2);
    tally_and_finish();
  end
endmodule
